// ---- design/synth_consts.svh ----
// register offsets, field positions, reset values and timing counts
`ifndef SYNTH_CONSTS_SVH
`define SYNTH_CONSTS_SVH
`define ADDR_STROBE      6'h00
`define ADDR_ENABLE      6'h01
`define ADDR_REFDIV      6'h03
`define ADDR_INT_WORD    6'h0f
`define ADDR_FRAC_WORD   6'h10
`define ADDR_DSM_CFG     6'h12
`define ADDR_SWEEP_CTRL  6'h14
`define ADDR_STEP_SIZE   6'h15
`define ADDR_STEP_COUNT  6'h16
`define ADDR_DWELL       6'h17
`define ADDR_GPO_CFG     6'h1b
`define ADDR_STATUS      6'h1f
`define STROBE_REGS_BIT  0
`define STROBE_DIG_BIT   1
`define EN_DSM_RUN_BIT   13
`define DSM_INT_MODE_BIT 3
`define GENERAL_OUTPUT_THREE_IN_EN_BIT   4
`define STATUS_BUSY_BIT  5
`define GENERAL_OUTPUT_TWO_SEL_BUSY    4'h8
`define INT_MIN          16'h0024
`define INT_MAX          16'hfffd
`define EN_RST           16'h2000
`define INT_RST          16'h0024
`define FRAC_RST         24'h000000
`define REFDIV_RST       14'h0001
`define DSM_CFG_RST      24'h000000
`define CFG24_RST        24'h000000
`define GPO_CFG_RST      24'h000000
`define CHIP_ID_VAL      24'h5a5a01
`define BIT_RD_LAST      6'h06
`define BIT_DATA_FIRST   6'h07
`define BIT_WR_LAST      6'h1e
`endif

// ---- design/synth_freq_ctrl_sweeper.sv ----
// frequency control, serial register port and sweep sequencer
`include "synth_consts.svh"
module synth_freq_ctrl_sweeper
	import synth_pkg::*;
#(
	parameter logic [23:0] CHIP_ID = `CHIP_ID_VAL  // arbitrary value
)(
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        sclk,
	input  wire logic        sen,
	input  wire logic        sdi,
	output logic             sdo,
	output logic             sdo_oe,
	input  wire logic        ref_in,
	input  wire logic        general_output_three,
	output logic             general_output_two,
	output logic [39:0]      freq_word,
	output logic             hop,
	output logic [13:0]      ref_div,
	output logic             ref_tick,
	output logic [15:0]      func_enables,
	output logic             powered_down,
	output logic             int_mode,
	output logic             dsm_run,
	output logic [1:0]       dsm_mode,
	output logic             dig_reset,
	output logic             sweep_busy
);
	// serial side, clocked by the host's clock
	logic        frame_rst_n;
	logic [5:0]  bit_cnt_r;
	logic [29:0] shin_r;
	wr_word_s    wr_hold_r;
	logic        wr_tgl_r;
	logic [5:0]  rd_addr_r;
	logic        rd_tgl_r;
	logic [23:0] out_sh_r;
	logic        sdo_r;
	logic        sdo_oe_r;
	// register side
	logic [2:0]  wr_sync_r;
	logic [2:0]  rd_sync_r;
	logic [23:0] rd_data_r;
	logic        wr_evt;
	logic        rd_evt;
	logic [15:0] en_r;
	logic [15:0] int_reg_r;
	logic [23:0] frac_reg_r;
	logic [13:0] refdiv_r;
	logic [23:0] dsm_cfg_r;
	sweep_ctrl_s ctrl_r;
	logic [23:0] step_r;
	logic [23:0] count_r;
	logic [23:0] dwell_r;
	logic [23:0] gpo_cfg_r;
	logic        strobe_regs;
	logic        strobe_dig;
	logic        int_mode_w;
	logic        hop_frac;
	logic        hop_int;
	// sweep
	logic [1:0]  ref_sync_r;
	logic        ref_prev_r;
	logic [13:0] ref_cnt_r;
	logic        tick_r;
	logic [1:0]  g3_sync_r;
	logic        g3_prev_r;
	logic        ext_evt;
	logic        sw_trig;
	logic        man_trig;
	logic        auto_trig;
	logic        trig_any;
	logic        step_go;
	logic        return_go;
	logic        start_go;
	sweep_state_e state_r;
	logic        started_r;
	logic        dir_r;
	logic [23:0] left_r;
	logic [23:0] dwell_cnt_r;
	logic [39:0] base_r;
	logic [39:0] freq_r;
	logic [39:0] freq_nxt;
	logic        hop_r;
	logic        busy_r;
	logic        general_output_two_r;
	logic        dig_rst_r;
	logic        pd_r;
	logic [39:0] target_r;

	assign frame_rst_n = sen & nrst;

	// bit counter and input shifter end with the frame's own enable
	always_ff @(posedge sclk or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			bit_cnt_r <= 6'h00;
			shin_r    <= 30'h00000000;
		end else begin
			if (bit_cnt_r != 6'h3f)
				bit_cnt_r <= bit_cnt_r + 6'h01;
			shin_r <= {shin_r[28:0], sdi};
		end
	end

	// completed write word crosses by toggle; word stays until next write
	always_ff @(posedge sclk or negedge nrst) begin
		if (!nrst) begin
			wr_hold_r <= '0;
			wr_tgl_r  <= 1'b0;
		end else if (sen && bit_cnt_r == `BIT_WR_LAST && !shin_r[29]) begin
			wr_hold_r <= wr_word_s'({shin_r, sdi});
			wr_tgl_r  <= ~wr_tgl_r;
		end
	end

	always_ff @(posedge sclk or negedge nrst) begin
		if (!nrst) begin
			rd_addr_r <= 6'h00;
			rd_tgl_r  <= 1'b0;
		end else if (sen && bit_cnt_r == `BIT_RD_LAST && shin_r[5]) begin
			rd_addr_r <= {shin_r[4:0], sdi};
			rd_tgl_r  <= ~rd_tgl_r;
		end
	end

	// rd_data_r settles within a few clk cycles of the address toggle;
	// one sclk period later it is loaded, so sclk must be slower than that
	always_ff @(posedge sclk or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			out_sh_r <= 24'h000000;
			sdo_r    <= 1'b0;
			sdo_oe_r <= 1'b0;
		end else if (bit_cnt_r == `BIT_DATA_FIRST && shin_r[6]) begin
			out_sh_r <= {rd_data_r[22:0], 1'b0};
			sdo_r    <= rd_data_r[23];
			sdo_oe_r <= 1'b1;
		end else if (sdo_oe_r) begin
			out_sh_r <= {out_sh_r[22:0], 1'b0};
			sdo_r    <= out_sh_r[23];
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wr_sync_r <= 3'h0;
			rd_sync_r <= 3'h0;
		end else begin
			wr_sync_r <= {wr_sync_r[1:0], wr_tgl_r};
			rd_sync_r <= {rd_sync_r[1:0], rd_tgl_r};
		end
	end

	assign wr_evt      = wr_sync_r[2] ^ wr_sync_r[1];
	assign rd_evt      = rd_sync_r[2] ^ rd_sync_r[1];
	assign strobe_regs = wr_evt && wr_hold_r.addr == `ADDR_STROBE
		&& wr_hold_r.data[`STROBE_REGS_BIT];
	assign strobe_dig  = wr_evt && wr_hold_r.addr == `ADDR_STROBE
		&& wr_hold_r.data[`STROBE_DIG_BIT];
	assign int_mode_w  = dsm_cfg_r[`DSM_INT_MODE_BIT];
	assign hop_frac    = wr_evt && wr_hold_r.addr == `ADDR_FRAC_WORD
		&& !int_mode_w;
	assign hop_int     = wr_evt && wr_hold_r.addr == `ADDR_INT_WORD
		&& int_mode_w && wr_hold_r.data[15:0] >= `INT_MIN
		&& wr_hold_r.data[15:0] <= `INT_MAX;
	// the written word must keep the sweeper on, else a trigger carried
	// by the disabling write starts a one-cycle ramp
	assign sw_trig     = wr_evt && wr_hold_r.addr == `ADDR_SWEEP_CTRL
		&& wr_hold_r.data[1]
		&& wr_hold_r.data[2];

	// port registers: held by nrst, returned to their reset values by the register strobe
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			en_r       <= `EN_RST;
			int_reg_r  <= `INT_RST;
			frac_reg_r <= `FRAC_RST;
			refdiv_r   <= `REFDIV_RST;
			dsm_cfg_r  <= `DSM_CFG_RST;
			ctrl_r     <= sweep_ctrl_s'(`CFG24_RST);
			step_r     <= `CFG24_RST;
			count_r    <= `CFG24_RST;
			dwell_r    <= `CFG24_RST;
			gpo_cfg_r  <= `GPO_CFG_RST;
		end else if (strobe_regs) begin
			en_r       <= `EN_RST;
			int_reg_r  <= `INT_RST;
			frac_reg_r <= `FRAC_RST;
			refdiv_r   <= `REFDIV_RST;
			dsm_cfg_r  <= `DSM_CFG_RST;
			ctrl_r     <= sweep_ctrl_s'(`CFG24_RST);
			step_r     <= `CFG24_RST;
			count_r    <= `CFG24_RST;
			dwell_r    <= `CFG24_RST;
			gpo_cfg_r  <= `GPO_CFG_RST;
		end else if (wr_evt) begin
			unique case (wr_hold_r.addr)
			`ADDR_ENABLE:     en_r <= wr_hold_r.data[15:0];
			`ADDR_INT_WORD: begin
				if (wr_hold_r.data[15:0] >= `INT_MIN
						&& wr_hold_r.data[15:0] <= `INT_MAX)
					int_reg_r <= wr_hold_r.data[15:0];
			end
			`ADDR_FRAC_WORD:  frac_reg_r <= wr_hold_r.data;
			`ADDR_REFDIV:     refdiv_r <= wr_hold_r.data[13:0];
			`ADDR_DSM_CFG:    dsm_cfg_r <= wr_hold_r.data;
			`ADDR_SWEEP_CTRL: begin
				ctrl_r      <= sweep_ctrl_s'(wr_hold_r.data);
				ctrl_r.trig <= 1'b0;
			end
			`ADDR_STEP_SIZE:  step_r <= wr_hold_r.data;
			`ADDR_STEP_COUNT: count_r <= wr_hold_r.data;
			`ADDR_DWELL:      dwell_r <= wr_hold_r.data;
			`ADDR_GPO_CFG:    gpo_cfg_r <= wr_hold_r.data;
			default: ;
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			rd_data_r <= 24'h000000;
		else if (rd_evt) begin
			unique case (rd_addr_r)
			`ADDR_STROBE:     rd_data_r <= CHIP_ID;
			`ADDR_ENABLE:     rd_data_r <= {8'h00, en_r};
			`ADDR_REFDIV:     rd_data_r <= {10'h000, refdiv_r};
			`ADDR_INT_WORD:   rd_data_r <= {8'h00, int_reg_r};
			`ADDR_FRAC_WORD:  rd_data_r <= frac_reg_r;
			`ADDR_DSM_CFG:    rd_data_r <= dsm_cfg_r;
			`ADDR_SWEEP_CTRL: rd_data_r <= 24'(ctrl_r);
			`ADDR_STEP_SIZE:  rd_data_r <= step_r;
			`ADDR_STEP_COUNT: rd_data_r <= count_r;
			`ADDR_DWELL:      rd_data_r <= dwell_r;
			`ADDR_GPO_CFG:    rd_data_r <= gpo_cfg_r;
			`ADDR_STATUS:
				rd_data_r <= 24'(busy_r) << `STATUS_BUSY_BIT;
			default:          rd_data_r <= 24'h000000;
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			dig_rst_r <= 1'b0;
		else
			dig_rst_r <= strobe_dig;
	end

	// reference pin sampled twice; divided by the programmed ratio
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ref_sync_r <= 2'h0;
			ref_prev_r <= 1'b0;
			ref_cnt_r  <= 14'h0000;
			tick_r     <= 1'b0;
		end else begin
			ref_sync_r <= {ref_sync_r[0], ref_in};
			ref_prev_r <= ref_sync_r[1];
			tick_r     <= 1'b0;
			if (strobe_dig)
				ref_cnt_r <= 14'h0000;
			else if (ref_sync_r[1] && !ref_prev_r) begin
				if (ref_cnt_r + 14'h0001 >= refdiv_r) begin
					ref_cnt_r <= 14'h0000;
					tick_r    <= 1'b1;
				end else
					ref_cnt_r <= ref_cnt_r + 14'h0001;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			g3_sync_r <= 2'h0;
			g3_prev_r <= 1'b0;
		end else begin
			g3_sync_r <= {g3_sync_r[0], general_output_three};
			g3_prev_r <= g3_sync_r[1];
		end
	end

	assign ext_evt   = g3_sync_r[1] && !g3_prev_r && ctrl_r.ext_en
		&& gpo_cfg_r[`GENERAL_OUTPUT_THREE_IN_EN_BIT];
	assign man_trig  = !ctrl_r.repeat_en && (sw_trig || ext_evt);
	assign auto_trig = ctrl_r.repeat_en && (state_r == ST_IDLE
		|| (state_r == ST_END && tick_r
		&& dwell_cnt_r >= dwell_r));
	assign trig_any  = ctrl_r.enable && (man_trig || auto_trig);
	assign step_go   = state_r == ST_RAMP && ctrl_r.enable
		&& (ctrl_r.single_step ? man_trig : tick_r);
	assign return_go = state_r == ST_END && trig_any
		&& ctrl_r.single_dir;
	assign start_go  = state_r != ST_RAMP && trig_any && !return_go;

	always_comb begin
		freq_nxt = freq_r;
		if (step_go) begin
			if (dir_r)
				freq_nxt = freq_r - {16'h0000, step_r};
			else
				freq_nxt = freq_r + {16'h0000, step_r};
		end else if (return_go)
			freq_nxt = base_r;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_r     <= ST_IDLE;
			started_r   <= 1'b0;
			dir_r       <= 1'b0;
			left_r      <= 24'h000000;
			dwell_cnt_r <= 24'h000000;
			base_r      <= 40'h0000000000;
			busy_r      <= 1'b0;
		end else if (strobe_dig || !ctrl_r.enable) begin
			state_r   <= ST_IDLE;
			started_r <= 1'b0;
			busy_r    <= 1'b0;
		end else begin
			if (state_r == ST_END && tick_r)
				dwell_cnt_r <= dwell_cnt_r + 24'h000001;
			if (start_go) begin
				if (!started_r) begin
					base_r    <= freq_r;
					dir_r     <= ctrl_r.dir_down;
					started_r <= 1'b1;
				end
				left_r  <= count_r;
				state_r <= count_r == 24'h000000 ? ST_END : ST_RAMP;
				busy_r  <= count_r != 24'h000000;
				dwell_cnt_r <= 24'h000000;
			end else if (return_go) begin
				state_r <= ST_IDLE;
			end else if (step_go) begin
				left_r <= left_r - 24'h000001;
				if (left_r == 24'h000001) begin
					state_r     <= ST_END;
					busy_r      <= 1'b0;
					dwell_cnt_r <= 24'h000000;
					if (!ctrl_r.single_dir)
						dir_r <= ~dir_r;
				end
			end
		end
	end

	// active word: hops from port writes win over sweep steps
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			freq_r <= {`INT_RST, `FRAC_RST};
			hop_r  <= 1'b0;
		end else begin
			hop_r <= hop_frac || hop_int || return_go;
			if (hop_frac)
				freq_r <= {int_reg_r, wr_hold_r.data};
			else if (hop_int)
				freq_r <= {wr_hold_r.data[15:0], freq_r[23:0]};
			else
				freq_r <= freq_nxt;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			general_output_two_r <= 1'b0;
			pd_r   <= 1'b0;
		end else begin
			general_output_two_r <= gpo_cfg_r[3:0] == `GENERAL_OUTPUT_TWO_SEL_BUSY && busy_r;
			pd_r   <= en_r == 16'h0000;
		end
	end

	// helper for checking: expected end point of the running ramp
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			target_r <= 40'h0000000000;
		else if (start_go) begin
			if ((started_r ? dir_r : ctrl_r.dir_down))
				// widened first so the product keeps its upper bits
				target_r <= freq_r - 40'(step_r) * 40'(count_r);
			else
				target_r <= freq_r + 40'(step_r) * 40'(count_r);
		end
	end

	assign sdo          = sdo_r;
	assign sdo_oe       = sdo_oe_r;
	assign general_output_two = general_output_two_r;
	assign freq_word    = freq_r;
	assign hop          = hop_r;
	assign ref_div      = refdiv_r;
	assign ref_tick     = tick_r;
	assign func_enables = en_r;
	assign powered_down = pd_r;
	assign int_mode     = int_mode_w;
	assign dsm_run      = en_r[`EN_DSM_RUN_BIT];
	assign dsm_mode     = dsm_cfg_r[9:8];
	assign dig_reset    = dig_rst_r;
	assign sweep_busy   = busy_r;

	a_frac_hop: assert property (@(posedge clk) disable iff (!nrst)
		hop_frac |=> hop_r && freq_r[23:0] == $past(wr_hold_r.data))
		else $error("fraction write did not hop");
	a_int_buffered: assert property (@(posedge clk) disable iff (!nrst)
		wr_evt && wr_hold_r.addr == `ADDR_INT_WORD && !int_mode_w
		&& !step_go && !return_go |=> $stable(freq_r))
		else $error("buffered integer word took effect");
	a_int_hop: assert property (@(posedge clk) disable iff (!nrst)
		hop_int |=> hop_r && freq_r[39:24] == $past(wr_hold_r.data[15:0]))
		else $error("integer write did not hop");
	a_strobe_regs: assert property (@(posedge clk) disable iff (!nrst)
		strobe_regs |=> en_r == `EN_RST && count_r == `CFG24_RST)
		else $error("register strobe left state");
	a_sweep_off: assert property (@(posedge clk) disable iff (!nrst)
		!ctrl_r.enable |=> state_r == ST_IDLE && !busy_r)
		else $error("sweeper active while disabled");
	a_step_size: assert property (@(posedge clk) disable iff (!nrst)
		step_go && !hop_frac && !hop_int |=> hop_r == 1'b0
		&& (freq_r - $past(freq_r) == {16'h0000, $past(step_r)}
		|| $past(freq_r) - freq_r == {16'h0000, $past(step_r)}))
		else $error("step differs from step size");
	a_ramp_end: assert property (@(posedge clk) disable iff (!nrst)
		$fell(busy_r) && $past(step_go) && !$past(hop_frac || hop_int)
		|-> freq_r == target_r)
		else $error("ramp ended off target");
	a_return_base: assert property (@(posedge clk) disable iff (!nrst)
		return_go && !hop_frac && !hop_int |=> freq_r == $past(base_r)
		&& hop_r && state_r == ST_IDLE)
		else $error("one-way return missed start");
	a_busy_pin: assert property (@(posedge clk) disable iff (!nrst)
		gpo_cfg_r[3:0] == `GENERAL_OUTPUT_TWO_SEL_BUSY && $stable(gpo_cfg_r)
		|=> general_output_two_r == $past(busy_r))
		else $error("output two does not follow busy");
	a_dwell_wait: assert property (@(posedge clk) disable iff (!nrst)
		state_r == ST_END && dwell_cnt_r < dwell_r |-> !auto_trig)
		else $error("retrigger before dwell elapsed");
	a_ext_gate: assert property (@(posedge clk) disable iff (!nrst)
		!(ctrl_r.ext_en && gpo_cfg_r[`GENERAL_OUTPUT_THREE_IN_EN_BIT]) && !ctrl_r.repeat_en
		&& !wr_evt && state_r != ST_RAMP |=> !busy_r)
		else $error("pin trigger while not enabled");
	c_ramp_done: cover property (@(posedge clk) disable iff (!nrst)
		$fell(busy_r));
	c_one_way_back: cover property (@(posedge clk) disable iff (!nrst)
		return_go);
	c_auto_retrig: cover property (@(posedge clk) disable iff (!nrst)
		auto_trig && state_r == ST_END);
	c_power_down: cover property (@(posedge clk) disable iff (!nrst)
		$rose(pd_r));
endmodule

// ---- design/synth_pkg.sv ----
// types shared by the frequency control and sweep block
package synth_pkg;
	typedef enum {ST_IDLE, ST_RAMP, ST_END} sweep_state_e;
	typedef struct packed {
		logic        rd;
		logic [5:0]  addr;
		logic [23:0] data;
	} wr_word_s;
	typedef struct packed {
		logic [15:0] rsvd_hi;
		logic        single_dir;
		logic        single_step;
		logic        ext_en;
		logic        dir_down;
		logic        repeat_en;
		logic        trig;
		logic        enable;
		logic        rsvd_lo;
	} sweep_ctrl_s;
endpackage

// ---- sim/serial_host.sv ----
// host controller model driving the four-wire serial port
module serial_host (
	output logic      sclk,
	output logic      sen,
	output logic      sdi,
	input  wire logic sdo,
	input  wire logic sdo_oe
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		sclk = 1'b0;
		sen = 1'b0;
		sdi = 1'b0;
	end

	// one frame: rd bit, 6 address bits, 24 data bits, one closing edge
	task automatic xfer(input logic rd, input logic [5:0] addr,
		input logic [23:0] data, output logic [23:0] q);
		logic [31:0] w;
		w = {rd, addr, data, 1'b0};
		q = 24'h000000;
		sen = 1'b1;
		for (int i = 0; i < 32; i++) begin
			sdi = w[31 - i];
			#80 sclk = 1'b1;
			#80 sclk = 1'b0;
			// undriven read data must not pass for a bit value
			if (i >= 7 && i <= 30)
				q = {q[22:0], (sdo_oe === 1'b1) ? sdo : 1'bx};
		end
		sen = 1'b0;
		// released line shows the inverse, never a stale level
		sdi = ~sdi;
		#100;
	endtask
endmodule

// ---- sim/tb_synth_freq_ctrl_sweeper.sv ----
// self-checking bench for the frequency control and sweep block
`include "synth_consts.svh"
module tb_synth_freq_ctrl_sweeper;
	timeunit 1ns;
	timeprecision 100ps;

	localparam logic [39:0] rst_f = {16'h0024, 24'h000000};
	localparam logic [39:0] base_f = {16'h0030, 24'h0a0000};
	localparam logic [39:0] delta = 40'h0004800000;

	logic        clk = 1'b0;
	logic        nrst, ref_in, general_output_three;
	logic        sclk, sen, sdi, sdo, sdo_oe, general_output_two;
	logic        hop, ref_tick, powered_down, int_mode, dsm_run;
	logic        dig_reset, sweep_busy;
	logic [39:0] freq_word;
	logic [13:0] ref_div;
	logic [15:0] func_enables;
	logic [1:0]  dsm_mode;
	logic [1:0]  ref_cnt = 2'h0;
	logic [23:0] q, saved;
	logic [23:0] int_in [4] = '{24'h000023, 24'h00fffe, 24'h00fffd,
		24'h000024};
	logic [23:0] int_exp [4] = '{24'h00005c, 24'h00005c, 24'h00fffd,
		24'h000024};
	int          mismatches, checks, cycles, hops, digs, ramps, h;
	int          seen_ramps, tick_cnt, tick_gap, run_len, idle_len;
	int          ramp_len, gap_len, busy_total, gpo_total;

	always #2.5 clk = ~clk;

	// reference of 8 clk periods, so ratio 2 gives a 16-cycle tick
	always @(negedge clk) begin
		ref_cnt <= ref_cnt + 2'h1;
		if (ref_cnt == 2'h3)
			ref_in <= ~ref_in;
	end

	synth_freq_ctrl_sweeper i_synth_freq_ctrl_sweeper (
		.clk                  (clk),
		.nrst                 (nrst),
		.sclk                 (sclk),
		.sen                  (sen),
		.sdi                  (sdi),
		.sdo                  (sdo),
		.sdo_oe               (sdo_oe),
		.ref_in               (ref_in),
		.general_output_three (general_output_three),
		.general_output_two   (general_output_two),
		.freq_word            (freq_word),
		.hop                  (hop),
		.ref_div              (ref_div),
		.ref_tick             (ref_tick),
		.func_enables         (func_enables),
		.powered_down         (powered_down),
		.int_mode             (int_mode),
		.dsm_run              (dsm_run),
		.dsm_mode             (dsm_mode),
		.dig_reset            (dig_reset),
		.sweep_busy           (sweep_busy)
	);

	serial_host i_serial_host (
		.sclk   (sclk),
		.sen    (sen),
		.sdi    (sdi),
		.sdo    (sdo),
		.sdo_oe (sdo_oe)
	);

	// pulse counts and busy run lengths, kept off the sampling edge
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (hop === 1'b1)
			hops <= hops + 1;
		if (dig_reset === 1'b1)
			digs <= digs + 1;
		if (general_output_two === 1'b1)
			gpo_total <= gpo_total + 1;
		if (ref_tick === 1'b1) begin
			tick_gap <= tick_cnt;
			tick_cnt <= 1;
		end else
			tick_cnt <= tick_cnt + 1;
		if (sweep_busy === 1'b1) begin
			busy_total <= busy_total + 1;
			run_len <= run_len + 1;
			idle_len <= 0;
			if (run_len == 0)
				gap_len <= idle_len;
		end else begin
			idle_len <= idle_len + 1;
			run_len <= 0;
			if (run_len != 0) begin
				ramp_len <= run_len;
				ramps <= ramps + 1;
			end
		end
	end

	task chk(input logic [39:0] seen, input logic [39:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task chk1(input logic b);
		chk({39'd0, b}, 40'd1);
	endtask

	task wr(input logic [5:0] a, input logic [23:0] d);
		i_serial_host.xfer(1'b0, a, d, q);
	endtask

	task rd(input logic [5:0] a, output logic [23:0] d);
		i_serial_host.xfer(1'b1, a, 24'h000000, d);
	endtask

	// waits for the next finished ramp, then checks end word and length
	task ramp_wait(input logic [39:0] exp);
		int n;
		n = 0;
		while (ramps == seen_ramps && n < 2000) begin
			@(negedge clk);
			n++;
		end
		seen_ramps = seen_ramps + 1;
		chk1(n < 2000);
		chk(freq_word, exp);
		chk1(ramp_len >= 112 && ramp_len <= 130);
	endtask

	// held 4 cycles so the two-flop synchroniser cannot miss it
	task pin_pulse;
		@(negedge clk) general_output_three = 1'b1;
		repeat (4) @(negedge clk);
		general_output_three = 1'b0;
	endtask

	task complete_run;
		$display("mismatches %0d checks %0d", mismatches, checks);
		if (mismatches == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	always @(negedge clk) begin
		if (cycles == 80000) begin
			mismatches++;
			$display("ERROR %0t run took too long", $time);
			complete_run;
		end
	end

	initial begin
		nrst = 1'b0;
		ref_in = 1'b0;
		general_output_three = 1'b0;
		repeat (4) @(negedge clk);
		nrst = 1'b1;
		repeat (2) @(negedge clk);
		chk(freq_word, rst_f);
		chk(ref_div, 14'h0001);
		chk(sweep_busy, 1'b0);
		wr(`ADDR_INT_WORD, 24'h00005c);
		chk(freq_word, rst_f);
		h = hops;
		wr(`ADDR_FRAC_WORD, 24'h0020c5);
		chk(freq_word, {16'h005c, 24'h0020c5});
		chk(hops, h + 1);
		rd(`ADDR_FRAC_WORD, q);
		chk(q, 24'h0020c5);
		for (int i = 0; i < 4; i++) begin
			wr(`ADDR_INT_WORD, int_in[i]);
			rd(`ADDR_INT_WORD, q);
			chk(q, int_exp[i]);
		end
		rd(`ADDR_ENABLE, saved);
		chk(saved, 24'h002000);
		wr(`ADDR_ENABLE, 24'h000000);
		chk(powered_down, 1'b1);
		wr(`ADDR_ENABLE, saved);
		chk(powered_down, 1'b0);
		chk(func_enables, saved);
		wr(`ADDR_DSM_CFG, 24'h000008);
		wr(`ADDR_ENABLE, 24'h000001);
		chk({int_mode, dsm_run}, 2'h2);
		h = hops;
		wr(`ADDR_INT_WORD, 24'h000030);
		chk(freq_word[39:24], 16'h0030);
		chk(hops, h + 1);
		wr(`ADDR_DSM_CFG, 24'h000300);
		wr(`ADDR_ENABLE, 24'h002000);
		chk({int_mode, dsm_mode}, 3'h3);
		wr(`ADDR_FRAC_WORD, 24'h0a0000);
		chk(freq_word, base_f);
		wr(`ADDR_REFDIV, 24'h000002);
		chk(ref_div, 14'h0002);
		chk(tick_gap, 16);
		wr(`ADDR_STEP_SIZE, 24'h900000);
		wr(`ADDR_STEP_COUNT, 24'h000008);
		wr(`ADDR_DWELL, 24'h000004);
		wr(`ADDR_GPO_CFG, 24'h000018);
		wr(`ADDR_SWEEP_CTRL, 24'h000022);
		wr(`ADDR_SWEEP_CTRL, 24'h000026);
		ramp_wait(base_f + delta);
		wr(`ADDR_SWEEP_CTRL, 24'h000026);
		ramp_wait(base_f);
		pin_pulse;
		ramp_wait(base_f + delta);
		wr(`ADDR_GPO_CFG, 24'h000008);
		pin_pulse;
		repeat (200) @(negedge clk);
		chk(ramps, seen_ramps);
		wr(`ADDR_SWEEP_CTRL, 24'h000000);
		wr(`ADDR_SWEEP_CTRL, 24'h000092);
		wr(`ADDR_SWEEP_CTRL, 24'h000096);
		ramp_wait(base_f);
		h = hops;
		wr(`ADDR_SWEEP_CTRL, 24'h000096);
		chk(freq_word, base_f + delta);
		chk(hops, h + 1);
		chk(ramps, seen_ramps);
		wr(`ADDR_SWEEP_CTRL, 24'h000096);
		ramp_wait(base_f);
		wr(`ADDR_SWEEP_CTRL, 24'h000004);
		repeat (200) @(negedge clk);
		chk(ramps, seen_ramps);
		chk(freq_word, base_f);
		wr(`ADDR_SWEEP_CTRL, 24'h000042);
		wr(`ADDR_SWEEP_CTRL, 24'h000046);
		rd(`ADDR_STATUS, q);
		chk(q, 24'h000020);
		chk(freq_word, base_f);
		wr(`ADDR_SWEEP_CTRL, 24'h000046);
		chk(freq_word, base_f + 40'h0000900000);
		wr(`ADDR_SWEEP_CTRL, 24'h000000);
		seen_ramps = ramps;
		wr(`ADDR_FRAC_WORD, 24'h0a0000);
		chk(freq_word, base_f);
		wr(`ADDR_SWEEP_CTRL, 24'h00000a);
		ramp_wait(base_f + delta);
		ramp_wait(base_f);
		chk1(gap_len >= 48 && gap_len <= 96);
		wr(`ADDR_SWEEP_CTRL, 24'h000000);
		repeat (200) @(negedge clk);
		chk(gpo_total, busy_total);
		h = digs;
		wr(`ADDR_STROBE, 24'h000002);
		chk(digs, h + 1);
		wr(`ADDR_STROBE, 24'h000001);
		chk({ref_div, func_enables}, {14'h0001, 16'h2000});
		rd(`ADDR_INT_WORD, q);
		chk(q, 24'h000024);
		wr(`ADDR_REFDIV, 24'h000005);
		chk(ref_div, 14'h0005);
		nrst = 1'b0;
		repeat (2) @(negedge clk);
		chk(ref_div, 14'h0001);
		nrst = 1'b1;
		repeat (2) @(negedge clk);
		complete_run;
	end
endmodule
